// >>> verification/qsau_ctrl_model.sv
// Behavioural model of the network motion controller driving the controlword
`timescale 1ns/1ns
module qsau_ctrl_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Requests from the bench
    input  wire logic qs_req,
    input  wire logic stop_req,
    // Controlword lines
    output logic      cw_quick_stop_n,
    output logic      cmd_stop
);
    // Quick stop bit idles high and drops only on request, since the bit is active low while the request is active high
    always_ff @(posedge clk) begin
        if (rst) begin
            cw_quick_stop_n <= 1'b1;
        end else begin
            cw_quick_stop_n <= ~qs_req;
        end
    end

    // Command stop follows the stop request one clock later and releases one clock after the request drops
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_stop <= 1'b0;
        end else begin
            cmd_stop <= stop_req;
        end
    end
endmodule : qsau_ctrl_model

// >>> verification/quick_stop_accel_unit_control_test.sv
// Self-checking bench for the quick stop and acceleration unit block
`timescale 1ns/1ns
module quick_stop_accel_unit_control_test;
    logic [7:0]           awaddr, araddr;
    logic [31:0]          wdata, rdata, act_speed, speed_cmd, rv;
    logic                 clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                 arvalid, arready, rvalid, rready, qs_req, stop_req, cw_qs_n, cmd_stop;
    logic                 enable_op, servo_on, dyn_brake;
    logic [1:0]           bresp, rresp, rr;
    logic [3:0]           accel_unit, cmd_unit;
    qsau_pkg::qsau_evt_t  evt;
    qsau_pkg::qsau_pds_t  pds;
    int                   n_fail, n_tests, seed;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    qsau_ctrl_model i_qsau_ctrl_model (.clk(clk), .rst(rst), .qs_req(qs_req), .stop_req(stop_req),
        .cw_quick_stop_n(cw_qs_n), .cmd_stop(cmd_stop));

    // Short millisecond count keeps time-constant ramps brief
    qsau_top #(.CYC_PER_MS(4)) i_qsau_top (.CORE_CLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CW_QUICK_STOP_N(cw_qs_n), .CMD_STOP(cmd_stop), .ENABLE_OP(enable_op), .DRIVE_EVT(evt),
        .ACT_SPEED(act_speed), .SERVO_ON(servo_on), .DYN_BRAKE(dyn_brake), .PDS_STATE(pds),
        .SPEED_CMD(speed_cmd), .ACCEL_UNIT(accel_unit), .CMD_UNIT(cmd_unit));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        // Ready is looked at mid-cycle, where it stands for the edge that follows
        do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        bready  <= 1'b1;
        do @(negedge clk); while (bvalid !== 1'b1);
        chk("bresp", 32'(bresp), 32'h0);
        @(posedge clk);
        bready  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(negedge clk); while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        @(posedge clk);
        rready  <= 1'b0;
    endtask : rd

    // Expected outcome worked out from method, mode, forced-stop enable, command stop and event
    task automatic run_case(input int m, input int md, input int fsd, input int cmd, input logic [2:0] e);
        logic [31:0] s;
        bit          brk, keep;
        s    = 32'(8 + ($random(seed) & 7));
        brk  = cmd == 1 || fsd == 0 || md inside {3, 6, 10} || !(m inside {1, 2, 5, 6});
        keep = !brk && m inside {5, 6} && e == 3'h0;
        wr(8'h00, {12'h0, 4'(md), 3'h0, 1'(fsd), 4'(m), 8'h01});
        @(posedge clk);
        enable_op <= 1'b1;
        act_speed <= s;
        @(posedge clk);
        enable_op <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("pds enabled", 32'(pds), 32'h1);
        @(posedge clk);
        qs_req   <= 1'b1;
        stop_req <= 1'(cmd);
        repeat (2) @(posedge clk);
        #1;
        if (brk) begin
            chk("pds brake", 32'(pds), 32'h0);
            chk("brake on", 32'(dyn_brake), 32'h1);
        end else begin
            chk("pds ramp", 32'(pds), 32'h2);
            chk("speed start", speed_cmd, s);
            repeat (2) @(posedge clk);
            #1 chk("speed slope", speed_cmd, s - 32'h2);
            if (e != 3'h0) begin
                @(posedge clk);
                evt <= e;
                repeat (2) @(posedge clk);
                #1 chk("pds event", 32'(pds), e[2] ? 32'h3 : 32'h2);
            end
        end
        repeat (40) @(posedge clk);
        #1 chk("pds final", 32'(pds), keep ? 32'h2 : 32'h0);
        chk("servo final", 32'(servo_on), 32'(keep));
        chk("brake final", 32'(dyn_brake), 32'(brk));
        @(posedge clk);
        qs_req   <= 1'b0;
        stop_req <= 1'b0;
        evt      <= 3'h0;
        repeat (3) @(posedge clk);
        #1 if (keep) chk("pds release", 32'(pds), 32'h1);
        $display("test case method %0d mode %0d done", m, md);
    endtask : run_case

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Generous bound: the whole sequence needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        {awaddr, araddr, wdata, act_speed} = '0;
        {awvalid, wvalid, bready, arvalid, rready, qs_req, stop_req, enable_op} = '0;
        evt     = 3'h0;
        n_fail  = 0;
        n_tests = 0;
        seed    = 32'h6c52;
        rst     = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00);
        chk("config reset", rv, 32'h0);
        rd(8'h10);
        chk("status reset", rv, 32'h0);
        rd(8'h18);
        chk("unmapped resp", 32'(rr), 32'h2);
        chk("unmapped data", rv, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(8'h00, {12'h0, 4'h1, 3'h0, 1'b1, 4'h2, 4'(p), 4'h1});
            #1 chk("cmd unit", 32'(cmd_unit), 32'(p));
            chk("accel unit", 32'(accel_unit), 32'h1);
        end
        wr(8'h04, 32'h0ee6b280);
        wr(8'h08, 32'h0ee6b280);
        wr(8'h0c, 32'h0ee6b280);
        wr(8'h00, {12'h0, 4'h1, 3'h0, 1'b1, 4'h2, 8'h30});
        #1 chk("accel unit ms", 32'(accel_unit), 32'h0);
        rd(8'h08);
        chk("ms store", rv, 32'h0);
        wr(8'h00, {12'h0, 4'h1, 3'h0, 1'b1, 4'h2, 8'h31});
        rd(8'h08);
        chk("unit store", rv, 32'h0ee6b280);
        @(posedge clk);
        qs_req <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("pds ignored", 32'(pds), 32'h0);
        @(posedge clk);
        qs_req <= 1'b0;
        // No operation mode selected: the request must not be acted on
        wr(8'h00, {12'h0, 4'h0, 3'h0, 1'b1, 4'h2, 8'h01});
        @(posedge clk);
        enable_op <= 1'b1;
        @(posedge clk);
        enable_op <= 1'b0;
        qs_req    <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("pds no mode", 32'(pds), 32'h1);
        @(posedge clk);
        qs_req <= 1'b0;
        $display("test registers done");
        run_case(2, 1, 1, 0, 3'h0);
        run_case(1, 4, 1, 0, 3'h0);
        run_case(5, 5, 1, 0, 3'h0);
        run_case(6, 8, 1, 0, 3'h0);
        run_case(0, 9, 1, 0, 3'h0);
        run_case(2, 3, 1, 0, 3'h0);
        run_case(2, 6, 1, 0, 3'h0);
        run_case(2, 10, 1, 0, 3'h0);
        run_case(2, 1, 0, 0, 3'h0);
        run_case(2, 1, 1, 1, 3'h0);
        run_case(6, 7, 1, 0, 3'h4);
        run_case(6, 2, 1, 0, 3'h2);
        run_case(5, 9, 1, 0, 3'h1);
        end_of_test();
    end
endmodule : quick_stop_accel_unit_control_test

// >>> verilog/qsau_params.svh
// Constants for the quick stop and acceleration unit block
`ifndef QSAU_PARAMS_SVH
`define QSAU_PARAMS_SVH

// Timing
`define QSAU_CLK_PERIOD_NS 4
`define QSAU_SEC_NS 1000000000
`define QSAU_MS_NS 1000000
`define QSAU_CLK_HZ (`QSAU_SEC_NS / `QSAU_CLK_PERIOD_NS)
`define QSAU_CYC_PER_MS (`QSAU_MS_NS / `QSAU_CLK_PERIOD_NS)
`define QSAU_RATED_SPEED 32'h00000bb8

// Register byte offsets
`define QSAU_REG_CONFIG 8'h00
`define QSAU_REG_MODE_DECEL 8'h04
`define QSAU_REG_QS_DECEL 8'h08
`define QSAU_REG_WARN_DECEL 8'h0c
`define QSAU_REG_STATUS 8'h10
`define QSAU_REG_SPEED 8'h14
`define QSAU_DECEL_STRIDE 8'h04

// Configuration fields
`define QSAU_ACCEL_LSB 0
`define QSAU_POSU_LSB 4
`define QSAU_METHOD_LSB 8
`define QSAU_FSD_EN_BIT 12
`define QSAU_MODE_LSB 16
`define QSAU_CONFIG_MASK 32'h000f1fff

// Reset values
`define QSAU_CONFIG_RST 32'h00000000
`define QSAU_DECEL_RST 32'h00000000

// Field codes
`define QSAU_UNIT_CMD 4'h1
`define QSAU_QSM_TC_OFF 4'h1
`define QSAU_QSM_QS_OFF 4'h2
`define QSAU_QSM_TC_ON 4'h5
`define QSAU_QSM_QS_ON 4'h6

// Bus answers
`define QSAU_RESP_OKAY 2'b00
`define QSAU_RESP_SLVERR 2'b10

`endif

// >>> verilog/qsau_pkg.sv
// Types for the quick stop and acceleration unit block
package qsau_pkg;

    typedef enum logic [1:0] {
        QSAU_SW_ON_DIS,
        QSAU_OP_EN,
        QSAU_QS_ACT,
        QSAU_FAULT_REACT
    } qsau_pds_t;

    typedef enum logic [3:0] {
        QSAU_NO_MODE,
        QSAU_CYC_SYNC_POS,
        QSAU_CYC_SYNC_VEL,
        QSAU_CYC_SYNC_TRQ,
        QSAU_PROFILE_POSITION,
        QSAU_PROFILE_VELOCITY,
        QSAU_PROFILE_TORQUE,
        QSAU_POINT_TABLE_MODE,
        QSAU_JOG_MODE,
        QSAU_HOMING_MODE,
        QSAU_CONT_TORQUE
    } qsau_mode_t;

    typedef enum logic [1:0] {
        QSAU_SEL_MODE,
        QSAU_SEL_QS,
        QSAU_SEL_WARN
    } qsau_sel_t;

    typedef struct packed {
        logic alarm_fsd;
        logic warn_fsd;
        logic warn_qs;
    } qsau_evt_t;

    typedef struct packed {
        logic [31:0] step;
        logic [47:0] scale;
    } qsau_rate_t;

endpackage : qsau_pkg

// >>> verilog/qsau_ramp.sv
// Deceleration ramp generator for the quick stop block
`timescale 1ns/1ns
module qsau_ramp (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Control
    input  wire logic              start,
    input  wire logic              abort,
    input  wire logic [31:0]       speed0,
    input  wire qsau_pkg::qsau_rate_t rate,
    // Result
    output logic      [31:0]       speed_ff,
    output logic                   busy_ff,
    output logic                   done_ff
);
    logic [47:0] frac_ff;
    logic [47:0] nxt_frac;

    // At most one speed unit per clock; faster rates saturate there
    assign nxt_frac = frac_ff + {16'h0000, rate.step};

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            speed_ff <= 32'h00000000;
            frac_ff  <= 48'h000000000000;
            busy_ff  <= 1'b0;
        end else if (start) begin
            speed_ff <= speed0;
            frac_ff  <= 48'h000000000000;
            busy_ff  <= 1'b1;
        end else if (busy_ff) begin
            if (speed_ff == 32'h00000000) begin
                busy_ff <= 1'b0;
            end else if (nxt_frac >= rate.scale) begin
                frac_ff  <= nxt_frac - rate.scale;
                speed_ff <= speed_ff - 32'h00000001;
            end else begin
                frac_ff <= nxt_frac;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= busy_ff && !start && (speed_ff == 32'h00000000);
        end
    end

endmodule : qsau_ramp

// >>> verilog/qsau_top.sv
// Quick stop sequencing and acceleration unit selection
`timescale 1ns/1ns
`include "qsau_params.svh"
// How it works
// - Quick stop low: ramp, then off or hold
// - Request acted on only in Operation Enabled
// - Forced stop disabled: dynamic brake always
// - Torque modes: dynamic brake, no ramp
// - Alarm mid-ramp: fault reaction, quick stop rate
// - Warning mid-ramp: stay, quick stop rate, off
// - Stop warning mid-ramp: its rate, off
// - Command stop wins: dynamic brake
// - Quick stop in all listed operation modes
// - Method taken from method selection field
// - Unit field: 0 milliseconds, 1 units/s2
// - Position unit: mm, inch, degree, pulse
// - Unit rate independent of rated speed
// - Same register, unit picks internal store
// - Method codes 0,1,2,5,6 map to actions
module qsau_top #(
    parameter int          AW          = 8,
    parameter int          CLK_HZ      = `QSAU_CLK_HZ,
    parameter int          CYC_PER_MS  = `QSAU_CYC_PER_MS,
    parameter logic [31:0] RATED_SPEED = `QSAU_RATED_SPEED
) (
    // Clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                SYS_RST,
    // AXI4-Lite slave
    input  wire logic [AW-1:0]       S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [AW-1:0]       S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    // Drive events and commands
    input  wire logic                CW_QUICK_STOP_N,
    input  wire logic                CMD_STOP,
    input  wire logic                ENABLE_OP,
    input  wire qsau_pkg::qsau_evt_t DRIVE_EVT,
    input  wire logic [31:0]         ACT_SPEED,
    // Drive state
    output logic                     SERVO_ON,
    output logic                     DYN_BRAKE,
    output qsau_pkg::qsau_pds_t      PDS_STATE,
    output logic [31:0]              SPEED_CMD,
    output logic [3:0]               ACCEL_UNIT,
    output logic [3:0]               CMD_UNIT
);
    logic [31:0]          cfg_ff;
    logic [31:0]          decel_ff [3][2];
    logic                 bvalid_ff;
    logic [1:0]           bresp_ff;
    logic                 rvalid_ff;
    logic [1:0]           rresp_ff;
    logic [31:0]          rdata_ff;
    logic                 wr_take;
    logic                 rd_take;
    logic                 unit_cmd;
    logic [3:0]           method;
    logic                 fsd_en;
    qsau_pkg::qsau_mode_t mode;
    logic                 mode_ok;
    qsau_pkg::qsau_pds_t  pds_ff;
    qsau_pkg::qsau_pds_t  nxt_pds;
    qsau_pkg::qsau_sel_t  sel_ff;
    qsau_pkg::qsau_sel_t  nxt_sel;
    logic                 keep_ff;
    logic                 nxt_keep;
    logic                 brake_ff;
    logic                 nxt_brake;
    logic                 servo_on_ff;
    logic                 ramp_go;
    logic                 ramp_stop;
    logic                 ramp_busy;
    logic                 ramp_done;
    logic [31:0]          ramp_speed;
    qsau_pkg::qsau_rate_t rate;

    function automatic logic is_torque(qsau_pkg::qsau_mode_t m);
        return m inside {qsau_pkg::QSAU_CYC_SYNC_TRQ, qsau_pkg::QSAU_PROFILE_TORQUE,
                         qsau_pkg::QSAU_CONT_TORQUE};
    endfunction : is_torque

    function automatic logic qs_ramps(logic [3:0] m);
        return m inside {`QSAU_QSM_TC_OFF, `QSAU_QSM_QS_OFF, `QSAU_QSM_TC_ON, `QSAU_QSM_QS_ON};
    endfunction : qs_ramps

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] data, logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic is_decel(logic [AW-1:0] a, int k);
        return a == AW'(`QSAU_REG_MODE_DECEL + k * `QSAU_DECEL_STRIDE);
    endfunction : is_decel

    // Configuration fields
    assign unit_cmd = cfg_ff[`QSAU_ACCEL_LSB +: 4] == `QSAU_UNIT_CMD;
    assign method   = cfg_ff[`QSAU_METHOD_LSB +: 4];
    assign fsd_en   = cfg_ff[`QSAU_FSD_EN_BIT];
    assign mode     = qsau_pkg::qsau_mode_t'(cfg_ff[`QSAU_MODE_LSB +: 4]);
    assign mode_ok  = mode != qsau_pkg::QSAU_NO_MODE;
    assign ACCEL_UNIT = cfg_ff[`QSAU_ACCEL_LSB +: 4];
    assign CMD_UNIT   = cfg_ff[`QSAU_POSU_LSB +: 4];

    // Bus handshakes; address and data are taken together
    assign wr_take       = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_ff;
    assign rd_take       = S_AXI_ARVALID && !rvalid_ff;
    assign S_AXI_AWREADY = wr_take;
    assign S_AXI_WREADY  = wr_take;
    assign S_AXI_ARREADY = rd_take;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RRESP   = rresp_ff;
    assign S_AXI_RDATA   = rdata_ff;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `QSAU_RESP_OKAY;
        end else if (wr_take) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (S_AXI_AWADDR <= AW'(`QSAU_REG_SPEED) && S_AXI_AWADDR[1:0] == 2'b00)
                         ? `QSAU_RESP_OKAY : `QSAU_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cfg_ff <= `QSAU_CONFIG_RST;
        end else if (wr_take && S_AXI_AWADDR == AW'(`QSAU_REG_CONFIG)) begin
            cfg_ff <= merge(cfg_ff, S_AXI_WDATA, S_AXI_WSTRB) & `QSAU_CONFIG_MASK;
        end
    end

    // One bus register per rate; the unit field picks which store it lands in
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            for (int k = 0; k < 3; k++) begin
                decel_ff[k][0] <= `QSAU_DECEL_RST;
                decel_ff[k][1] <= `QSAU_DECEL_RST;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (wr_take && is_decel(S_AXI_AWADDR, k)) begin
                    decel_ff[k][unit_cmd] <= merge(decel_ff[k][unit_cmd], S_AXI_WDATA, S_AXI_WSTRB);
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `QSAU_RESP_OKAY;
            rdata_ff  <= 32'h00000000;
        end else if (rd_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= `QSAU_RESP_OKAY;
            rdata_ff  <= 32'h00000000;
            if (S_AXI_ARADDR == AW'(`QSAU_REG_CONFIG)) begin
                rdata_ff <= cfg_ff;
            end else if (S_AXI_ARADDR == AW'(`QSAU_REG_STATUS)) begin
                rdata_ff <= {27'h0000000, ramp_busy, brake_ff, servo_on_ff, pds_ff};
            end else if (S_AXI_ARADDR == AW'(`QSAU_REG_SPEED)) begin
                rdata_ff <= ramp_speed;
            end else if (is_decel(S_AXI_ARADDR, 0)) begin
                rdata_ff <= decel_ff[0][unit_cmd];
            end else if (is_decel(S_AXI_ARADDR, 1)) begin
                rdata_ff <= decel_ff[1][unit_cmd];
            end else if (is_decel(S_AXI_ARADDR, 2)) begin
                rdata_ff <= decel_ff[2][unit_cmd];
            end else begin
                rresp_ff <= `QSAU_RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Unit rate ignores rated speed; time constant scales rated speed over tc ms
    always_comb begin
        if (unit_cmd) begin
            rate.step  = decel_ff[sel_ff][1];
            rate.scale = 48'(CLK_HZ);
        end else begin
            rate.step  = RATED_SPEED;
            rate.scale = 48'(decel_ff[sel_ff][0][15:0]) * 48'(CYC_PER_MS);
        end
    end

    // Power drive state sequencing
    always_comb begin
        nxt_pds   = pds_ff;
        nxt_sel   = sel_ff;
        nxt_keep  = keep_ff;
        nxt_brake = brake_ff;
        ramp_go   = 1'b0;
        ramp_stop = 1'b0;
        unique case (pds_ff)
            qsau_pkg::QSAU_SW_ON_DIS: begin
                if (ENABLE_OP && CW_QUICK_STOP_N) begin
                    nxt_pds   = qsau_pkg::QSAU_OP_EN;
                    nxt_brake = 1'b0;
                end
            end
            qsau_pkg::QSAU_OP_EN: begin
                if (!CW_QUICK_STOP_N && mode_ok) begin
                    if (CMD_STOP || !fsd_en || is_torque(mode) || !qs_ramps(method)) begin
                        nxt_pds   = qsau_pkg::QSAU_SW_ON_DIS;
                        nxt_brake = 1'b1;
                        ramp_stop = 1'b1;
                    end else begin
                        nxt_pds  = qsau_pkg::QSAU_QS_ACT;
                        nxt_keep = method inside {`QSAU_QSM_TC_ON, `QSAU_QSM_QS_ON};
                        nxt_sel  = (method inside {`QSAU_QSM_TC_OFF, `QSAU_QSM_TC_ON})
                                   ? qsau_pkg::QSAU_SEL_MODE : qsau_pkg::QSAU_SEL_QS;
                        ramp_go  = 1'b1;
                    end
                end
            end
            qsau_pkg::QSAU_QS_ACT: begin
                if (ramp_busy) begin
                    if (DRIVE_EVT.alarm_fsd) begin
                        nxt_pds  = qsau_pkg::QSAU_FAULT_REACT;
                        nxt_keep = 1'b0;
                        nxt_sel  = qsau_pkg::QSAU_SEL_QS;
                    end else if (DRIVE_EVT.warn_fsd) begin
                        nxt_keep = 1'b0;
                        nxt_sel  = qsau_pkg::QSAU_SEL_QS;
                    end else if (DRIVE_EVT.warn_qs) begin
                        nxt_keep = 1'b0;
                        nxt_sel  = qsau_pkg::QSAU_SEL_WARN;
                    end
                end else if (ramp_done && !keep_ff) begin
                    nxt_pds = qsau_pkg::QSAU_SW_ON_DIS;
                end else if (!ramp_done && keep_ff && CW_QUICK_STOP_N) begin
                    nxt_pds = qsau_pkg::QSAU_OP_EN;
                end
            end
            qsau_pkg::QSAU_FAULT_REACT: begin
                if (ramp_done) begin
                    nxt_pds = qsau_pkg::QSAU_SW_ON_DIS;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pds_ff <= qsau_pkg::QSAU_SW_ON_DIS;
        end else begin
            pds_ff <= nxt_pds;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sel_ff  <= qsau_pkg::QSAU_SEL_QS;
            keep_ff <= 1'b0;
        end else begin
            sel_ff  <= nxt_sel;
            keep_ff <= nxt_keep;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            brake_ff    <= 1'b0;
            servo_on_ff <= 1'b0;
        end else begin
            brake_ff    <= nxt_brake;
            servo_on_ff <= nxt_pds != qsau_pkg::QSAU_SW_ON_DIS;
        end
    end

    assign SERVO_ON  = servo_on_ff;
    assign DYN_BRAKE = brake_ff;
    assign PDS_STATE = pds_ff;
    assign SPEED_CMD = ramp_speed;

    qsau_ramp u_ramp (
        .clk      (CORE_CLK),
        .rst      (SYS_RST),
        .start    (ramp_go),
        .abort    (ramp_stop),
        .speed0   (ACT_SPEED),
        .rate     (rate),
        .speed_ff (ramp_speed),
        .busy_ff  (ramp_busy),
        .done_ff  (ramp_done)
    );

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_qs_op;
        pds_ff == qsau_pkg::QSAU_OP_EN && !CW_QUICK_STOP_N && mode_ok;
    endsequence

    sequence s_ramping;
        pds_ff == qsau_pkg::QSAU_QS_ACT && ramp_busy;
    endsequence

    a_qs_ramp_start: assert property (
        s_qs_op ##0 (fsd_en && !CMD_STOP && !is_torque(mode) && qs_ramps(method))
        |=> ramp_busy && pds_ff == qsau_pkg::QSAU_QS_ACT && SERVO_ON)
        else $error("quick stop did not start a ramp");
    a_qs_ignored: assert property (
        pds_ff == qsau_pkg::QSAU_SW_ON_DIS && !CW_QUICK_STOP_N |=> pds_ff == qsau_pkg::QSAU_SW_ON_DIS && !ramp_busy)
        else $error("request acted on outside operation enabled");
    a_fsd_off_brake: assert property (
        s_qs_op ##0 !fsd_en |=> DYN_BRAKE && !SERVO_ON && !ramp_busy)
        else $error("no dynamic brake with forced stop disabled");
    a_torque_brake: assert property (
        s_qs_op ##0 is_torque(mode) |=> DYN_BRAKE && !ramp_busy)
        else $error("torque mode ramped instead of braking");
    a_alarm_fault: assert property (
        s_ramping ##0 DRIVE_EVT.alarm_fsd |=> pds_ff == qsau_pkg::QSAU_FAULT_REACT && sel_ff == qsau_pkg::QSAU_SEL_QS)
        else $error("alarm during ramp did not enter fault reaction");
    a_warn_stays: assert property (
        s_ramping ##0 (DRIVE_EVT.warn_fsd && !DRIVE_EVT.alarm_fsd)
        |=> pds_ff == qsau_pkg::QSAU_QS_ACT && !keep_ff && sel_ff == qsau_pkg::QSAU_SEL_QS)
        else $error("warning during ramp handled wrongly");
    a_warn_own_rate: assert property (
        s_ramping ##0 (DRIVE_EVT.warn_qs && !DRIVE_EVT.warn_fsd && !DRIVE_EVT.alarm_fsd)
        |=> sel_ff == qsau_pkg::QSAU_SEL_WARN && !keep_ff)
        else $error("stop warning did not select its own rate");
    a_cmd_stop_wins: assert property (
        s_qs_op ##0 CMD_STOP |=> DYN_BRAKE && pds_ff == qsau_pkg::QSAU_SW_ON_DIS ##1 !ramp_busy)
        else $error("command stop did not win");
    a_keep_servo: assert property (
        pds_ff == qsau_pkg::QSAU_QS_ACT && ramp_done && keep_ff |=> SERVO_ON && pds_ff == qsau_pkg::QSAU_QS_ACT)
        else $error("servo not kept on after hold method");
    a_unit_store: assert property (
        wr_take && is_decel(S_AXI_AWADDR, 1) && S_AXI_WSTRB == 4'hf && unit_cmd
        |=> decel_ff[1][1] == $past(S_AXI_WDATA) && $stable(decel_ff[1][0]))
        else $error("rate not stored by unit");

endmodule : qsau_top
